// file: pbrs_map.svh
`ifndef PBRS_MAP_SVH
`define PBRS_MAP_SVH
// Clock rate in kHz
`define PBRS_CLK_KHZ 20000
// Extension delays in microseconds (longest times, round down)
`define PBRS_POR_EXT_US 30
`define PBRS_BOR_EXT_US 100
`define PBRS_POR_EXT_CYC ((`PBRS_POR_EXT_US * `PBRS_CLK_KHZ) / 1000)
`define PBRS_BOR_EXT_CYC ((`PBRS_BOR_EXT_US * `PBRS_CLK_KHZ) / 1000)
// Clock monitor limit in microseconds
`define PBRS_CLKMON_US 900
`define PBRS_CLKMON_CYC ((`PBRS_CLKMON_US * `PBRS_CLK_KHZ) / 1000)
// Power-up timer top setting in milliseconds
`define PBRS_POWER_UP_TIMER_MAX_MS 128
`define PBRS_POWER_UP_TIMER_MAX_CYC (`PBRS_POWER_UP_TIMER_MAX_MS * `PBRS_CLK_KHZ)
// Status field positions and values (the status register itself resets to 2'h1, power-on flag set)
`define PBRS_STAT_POR_BIT 0
`define PBRS_STAT_BOR_BIT 1
`define PBRS_STAT_RST 2'h0
`define PBRS_CNT_W 22
`endif

// file: pbrs_pkg.sv
package pbrs_pkg;
   typedef enum logic [2:0] {
      PBRS_OFF = 3'h0,
      PBRS_POR_EXT = 3'h1,
      PBRS_BOR_EXT = 3'h2,
      PBRS_POWER_UP_TIMER = 3'h3,
      PBRS_RUN = 3'h4
   } pbrs_state_t;
   typedef struct packed {
      logic por_ok;
      logic bor_ok;
   } pbrs_supply_t;
   typedef struct packed {
      logic bor_flag;
      logic por_flag;
   } pbrs_status_t;
endpackage

// file: pbrs_clkmon.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbrs_map.svh"
module pbrs_clkmon #(
   parameter int unsigned LIMIT_CYC = `PBRS_CLKMON_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic mon_tick,
   output logic clk_fail
);
   logic [14:0] cnt_r;
   logic [14:0] cnt_nxt;
   logic tick_d_r;
   logic fail_r;
   logic fail_nxt;
   // Count cycles between edges of the monitored clock
   always_comb begin
      cnt_nxt = cnt_r;
      fail_nxt = fail_r;
      if (mon_tick != tick_d_r) begin
         cnt_nxt = 15'h0000;
      end else if (cnt_r >= LIMIT_CYC[14:0] - 15'h0001) begin
         fail_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + 15'h0001;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 15'h0000;
         tick_d_r <= 1'b0;
         fail_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_d_r <= mon_tick;
         fail_r <= fail_nxt;
      end
   end
   assign clk_fail = fail_r;
   property p_fail_bound;
      @(posedge sys_clk) disable iff (!rst_b)
      (mon_tick == tick_d_r) [*1] ##0 (cnt_r == LIMIT_CYC[14:0] - 15'h0001) |=> fail_r;
   endproperty
   a_fail_bound: assert property (p_fail_bound) else $error("clock fail not flagged in time");
endmodule
`default_nettype wire

// file: pbrs_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "pbrs_map.svh"
module pbrs_sequencer #(
   parameter int unsigned POWER_UP_TIMER_UNIT_CYC = `PBRS_CLK_KHZ,
   parameter int unsigned CLKMON_CYC = `PBRS_CLKMON_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire pbrs_pkg::pbrs_supply_t supply,
   input wire logic [2:0] power_up_delay_select,
   input wire logic status_clear_por,
   input wire logic status_clear_bor,
   input wire logic mon_tick,
   output logic system_reset,
   output pbrs_pkg::pbrs_status_t reset_control_status_reg,
   output logic clk_fail
);
   localparam logic [21:0] POR_EXT = 22'(`PBRS_POR_EXT_CYC);
   localparam logic [21:0] BOR_EXT = 22'(`PBRS_BOR_EXT_CYC);
   pbrs_pkg::pbrs_state_t state_r;
   pbrs_pkg::pbrs_state_t state_nxt;
   logic [21:0] cnt_r;
   logic [21:0] cnt_nxt;
   logic [21:0] power_up_timer_len;
   logic por_r;
   logic por_nxt;
   logic bor_r;
   logic bor_nxt;
   logic rst_nxt;
   logic rst_r;
   ////////////////////////////////////////////////////////////////////////
   // Power-up delay lookup: 0 then 2,4,...,128 ms
   always_comb begin
      unique case (power_up_delay_select)
         3'h0: power_up_timer_len = 22'h000000;
         3'h1: power_up_timer_len = 22'(2 * POWER_UP_TIMER_UNIT_CYC);
         3'h2: power_up_timer_len = 22'(4 * POWER_UP_TIMER_UNIT_CYC);
         3'h3: power_up_timer_len = 22'(8 * POWER_UP_TIMER_UNIT_CYC);
         3'h4: power_up_timer_len = 22'(16 * POWER_UP_TIMER_UNIT_CYC);
         3'h5: power_up_timer_len = 22'(32 * POWER_UP_TIMER_UNIT_CYC);
         3'h6: power_up_timer_len = 22'(64 * POWER_UP_TIMER_UNIT_CYC);
         3'h7: power_up_timer_len = 22'(`PBRS_POWER_UP_TIMER_MAX_MS * POWER_UP_TIMER_UNIT_CYC);
      endcase
   end
   ////////////////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      por_nxt = por_r;
      bor_nxt = bor_r;
      // Clear first so that a cause event in the same cycle wins
      if (status_clear_por) begin
         por_nxt = 1'b0;
      end
      if (status_clear_bor) begin
         bor_nxt = 1'b0;
      end
      if (!supply.por_ok) begin
         state_nxt = pbrs_pkg::PBRS_OFF;
         cnt_nxt = 22'h000000;
         por_nxt = 1'b1;
      end else if (!supply.bor_ok) begin
         // A brown-out drop restarts the chain at the brown-out extension
         state_nxt = pbrs_pkg::PBRS_BOR_EXT;
         cnt_nxt = 22'h000000;
         if (state_r != pbrs_pkg::PBRS_OFF && state_r != pbrs_pkg::PBRS_POR_EXT) begin
            bor_nxt = 1'b1;
         end
      end else begin
         unique case (state_r)
            pbrs_pkg::PBRS_OFF: begin
               state_nxt = pbrs_pkg::PBRS_POR_EXT;
               cnt_nxt = 22'h000000;
            end
            pbrs_pkg::PBRS_POR_EXT: begin
               if (cnt_r >= POR_EXT - 22'h000001) begin
                  state_nxt = pbrs_pkg::PBRS_BOR_EXT;
                  cnt_nxt = 22'h000000;
               end else begin
                  cnt_nxt = cnt_r + 22'h000001;
               end
            end
            pbrs_pkg::PBRS_BOR_EXT: begin
               if (cnt_r >= BOR_EXT - 22'h000001) begin
                  state_nxt = pbrs_pkg::PBRS_POWER_UP_TIMER;
                  cnt_nxt = 22'h000000;
               end else begin
                  cnt_nxt = cnt_r + 22'h000001;
               end
            end
            pbrs_pkg::PBRS_POWER_UP_TIMER: begin
               if (cnt_r >= power_up_timer_len) begin
                  state_nxt = pbrs_pkg::PBRS_RUN;
               end else begin
                  cnt_nxt = cnt_r + 22'h000001;
               end
            end
            pbrs_pkg::PBRS_RUN: begin
               state_nxt = pbrs_pkg::PBRS_RUN;
            end
            default: begin
               state_nxt = pbrs_pkg::PBRS_OFF;
            end
         endcase
      end
      // Reset stays asserted in every state but run
      rst_nxt = (state_nxt != pbrs_pkg::PBRS_RUN);
   end
   ////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= pbrs_pkg::PBRS_OFF;
         cnt_r <= 22'h000000;
         por_r <= 1'b1;
         bor_r <= 1'b0;
         rst_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         por_r <= por_nxt;
         bor_r <= bor_nxt;
         rst_r <= rst_nxt;
      end
   end
   assign system_reset = rst_r;
   assign reset_control_status_reg.por_flag = por_r;
   assign reset_control_status_reg.bor_flag = bor_r;
   ////////////////////////////////////////////////////////////////////////
   // Missing clock monitor
   pbrs_clkmon #(
      .LIMIT_CYC(CLKMON_CYC)
   ) u_clkmon (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .mon_tick(mon_tick),
      .clk_fail(clk_fail)
   );
   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_por_hold;
      @(posedge sys_clk) disable iff (!rst_b)
      !supply.por_ok |=> system_reset && state_r == pbrs_pkg::PBRS_OFF;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("reset not held at low supply");
   property p_por_flag;
      @(posedge sys_clk) disable iff (!rst_b)
      !supply.por_ok |=> reset_control_status_reg.por_flag;
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("power-on flag not set");
   property p_bor_hold;
      @(posedge sys_clk) disable iff (!rst_b)
      supply.por_ok && !supply.bor_ok |=> system_reset && cnt_r == 22'h000000;
   endproperty
   a_bor_hold: assert property (p_bor_hold) else $error("brown-out did not restart");
   property p_bor_flag;
      @(posedge sys_clk) disable iff (!rst_b)
      supply.por_ok && !supply.bor_ok && state_r == pbrs_pkg::PBRS_RUN |=> reset_control_status_reg.bor_flag;
   endproperty
   a_bor_flag: assert property (p_bor_flag) else $error("brown-out flag not set");
   property p_bor_len;
      @(posedge sys_clk) disable iff (!rst_b)
      $rose(state_r == pbrs_pkg::PBRS_BOR_EXT) && supply.bor_ok |-> (state_r == pbrs_pkg::PBRS_BOR_EXT
         || !supply.bor_ok || !supply.por_ok) [*2];
   endproperty
   a_bor_len: assert property (p_bor_len) else $error("brown-out extension cut short");
   property p_release;
      @(posedge sys_clk) disable iff (!rst_b)
      $fell(system_reset) |-> $past(state_r) == pbrs_pkg::PBRS_POWER_UP_TIMER && $past(cnt_r) >= $past(power_up_timer_len);
   endproperty
   a_release: assert property (p_release) else $error("reset released before timer end");
   property p_sel_zero;
      @(posedge sys_clk) disable iff (!rst_b)
      state_r == pbrs_pkg::PBRS_POWER_UP_TIMER && power_up_delay_select == 3'h0 && supply.bor_ok && supply.por_ok
         |=> !system_reset;
   endproperty
   a_sel_zero: assert property (p_sel_zero) else $error("zero delay not immediate");
   property p_sticky;
      @(posedge sys_clk) disable iff (!rst_b)
      reset_control_status_reg.por_flag && !status_clear_por |=> reset_control_status_reg.por_flag;
   endproperty
   a_sticky: assert property (p_sticky) else $error("power-on flag dropped");
   property p_por_ext_len;
      @(posedge sys_clk) disable iff (!rst_b)
      state_r == pbrs_pkg::PBRS_POR_EXT && cnt_r < POR_EXT - 22'h000001 && supply.por_ok && supply.bor_ok
         |=> state_r == pbrs_pkg::PBRS_POR_EXT && system_reset;
   endproperty
   a_por_ext_len: assert property (p_por_ext_len) else $error("power-on extension cut short");
   property p_bor_ext_len;
      @(posedge sys_clk) disable iff (!rst_b)
      state_r == pbrs_pkg::PBRS_BOR_EXT && cnt_r < BOR_EXT - 22'h000001 && supply.por_ok && supply.bor_ok
         |=> state_r == pbrs_pkg::PBRS_BOR_EXT && system_reset;
   endproperty
   a_bor_ext_len: assert property (p_bor_ext_len) else $error("brown-out extension cut short");
   property p_power_up_timer_hold;
      @(posedge sys_clk) disable iff (!rst_b)
      state_r == pbrs_pkg::PBRS_POWER_UP_TIMER && cnt_r < power_up_timer_len && supply.por_ok && supply.bor_ok
         |=> state_r == pbrs_pkg::PBRS_POWER_UP_TIMER && system_reset;
   endproperty
   a_power_up_timer_hold: assert property (p_power_up_timer_hold) else $error("power-up timer cut short");
   property p_run_stay;
      @(posedge sys_clk) disable iff (!rst_b)
      state_r == pbrs_pkg::PBRS_RUN && supply.por_ok && supply.bor_ok |=> !system_reset;
   endproperty
   a_run_stay: assert property (p_run_stay) else $error("reset raised with good supply");
   property p_por_clear;
      @(posedge sys_clk) disable iff (!rst_b)
      status_clear_por && supply.por_ok |=> !reset_control_status_reg.por_flag;
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("power-on flag not cleared");
   property p_bor_clear;
      @(posedge sys_clk) disable iff (!rst_b)
      status_clear_bor && supply.bor_ok |=> !reset_control_status_reg.bor_flag;
   endproperty
   a_bor_clear: assert property (p_bor_clear) else $error("brown-out flag not cleared");
endmodule
`default_nettype wire

// file: pbrs_sequencer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pbrs_sequencer_bench;
   localparam int UNIT = 10;
   localparam int MON = 20;
   localparam int EXT = 2000;
   localparam int PEXT = 600;
   logic sys_clk;
   logic rst_b;
   pbrs_pkg::pbrs_supply_t supply;
   logic [2:0] sel;
   logic clr_por;
   logic clr_bor;
   logic mon_tick;
   logic tick_en;
   logic system_reset;
   pbrs_pkg::pbrs_status_t stat;
   logic clk_fail;
   int fail_count;
   int n_compared;
   int n;
   pbrs_sequencer #(.POWER_UP_TIMER_UNIT_CYC(UNIT), .CLKMON_CYC(MON)) DUT (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .supply(supply),
      .power_up_delay_select(sel),
      .status_clear_por(clr_por),
      .status_clear_bor(clr_bor),
      .mon_tick(mon_tick),
      .system_reset(system_reset),
      .reset_control_status_reg(stat),
      .clk_fail(clk_fail)
   );
   ////////////////////////////////////////////////////////////////////////
   // Clock and monitored activity
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (!rst_b) mon_tick <= 1'b0;
      else if (tick_en) mon_tick <= ~mon_tick;
   end
   ////////////////////////////////////////////////////////////////////////
   // One compare per kind of result: levels, cause flags, cycle counts
   task automatic chk_lvl(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_stat(input logic [1:0] got, input logic [1:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Count edges until reset is released, bounded
   task automatic wait_rel(input int lim);
      n = 0;
      while (system_reset !== 1'b0 && n < lim) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask
   task automatic t_power_on();
      #1;
      chk_lvl(system_reset, 1'b1);
      chk_stat(stat, 2'h1);
      repeat (100) @(posedge sys_clk);
      #1;
      chk_lvl(system_reset, 1'b1);
      @(posedge sys_clk);
      sel <= 3'h0;
      supply <= 2'h3;
      wait_rel(3000);
      chk_cnt(n, PEXT + EXT + 2);
      chk_stat(stat, 2'h1);
   endtask
   // Brown-out with a given delay select; expected flags passed in
   task automatic t_brown(input logic [2:0] s, input logic [1:0] st);
      int len;
      len = (s == 3'h0) ? 0 : (UNIT << s);
      @(posedge sys_clk);
      sel <= s;
      supply.bor_ok <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk_lvl(system_reset, 1'b1);
      chk_stat(stat, st);
      @(posedge sys_clk);
      supply.bor_ok <= 1'b1;
      wait_rel(EXT + len + 50);
      chk_cnt(n, EXT + len + 1);
   endtask
   task automatic t_restart();
      @(posedge sys_clk);
      sel <= 3'h3;
      supply.bor_ok <= 1'b0;
      repeat (2) @(posedge sys_clk);
      supply.bor_ok <= 1'b1;
      repeat (1500) @(posedge sys_clk);
      supply.bor_ok <= 1'b0;
      repeat (2) @(posedge sys_clk);
      supply.bor_ok <= 1'b1;
      #1;
      chk_lvl(system_reset, 1'b1);
      wait_rel(EXT + 200);
      chk_cnt(n, EXT + (UNIT << 3) + 1);
   endtask
   task automatic t_clear(input logic p, input logic b, input logic [1:0] st);
      @(posedge sys_clk);
      clr_por <= p;
      clr_bor <= b;
      @(posedge sys_clk);
      clr_por <= 1'b0;
      clr_bor <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk_stat(stat, st);
   endtask
   task automatic t_clkmon();
      #1;
      chk_lvl(clk_fail, 1'b0);
      @(posedge sys_clk);
      tick_en <= 1'b0;
      repeat (MON / 2) @(posedge sys_clk);
      #1;
      chk_lvl(clk_fail, 1'b0);
      repeat (MON) @(posedge sys_clk);
      #1;
      chk_lvl(clk_fail, 1'b1);
   endtask
   // Clear and brown-out in the same cycle: the cause flag must survive
   task automatic t_clash();
      @(posedge sys_clk);
      clr_bor <= 1'b1;
      supply.bor_ok <= 1'b0;
      @(posedge sys_clk);
      clr_bor <= 1'b0;
      supply.bor_ok <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk_stat(stat, 2'h2);
      wait_rel(EXT + 100);
      chk_lvl(system_reset, 1'b0);
   endtask
   task automatic finish_test();
      $display("compared=%0d mismatches=%0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (60000) @(posedge sys_clk);
      fail_count++;
      finish_test();
   end
   // Main sequence
   initial begin
      fail_count = 0;
      n_compared = 0;
      rst_b = 1'b0;
      supply = 2'h0;
      sel = 3'h0;
      clr_por = 1'b0;
      clr_bor = 1'b0;
      tick_en = 1'b1;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_power_on();
      for (int s = 0; s < 8; s++) begin
         t_brown(s[2:0], 2'h3);
      end
      t_restart();
      t_clear(1'b1, 1'b0, 2'h2);
      t_clear(1'b0, 1'b1, 2'h0);
      t_brown(3'h1, 2'h2);
      t_clash();
      t_clkmon();
      finish_test();
   end
endmodule
`default_nettype wire
